//--- design/asfs_pkg.sv
// constants and carrier types of the serial frame sequencer
package asfs_pkg;
  localparam int unsigned RES_W         = 12;
  localparam int unsigned IDX_W         = 4;
  localparam int unsigned CHAN_W        = 2;
  localparam int unsigned CTL_W         = 8;
  localparam logic [3:0]  HOLD_IDX      = 4'h3;
  localparam logic [3:0]  FIRST_BIT_IDX = 4'h4;
  localparam logic [3:0]  LAST_IDX      = 4'hf;
  localparam logic [3:0]  CTL_BITS      = 4'h8;
  localparam int unsigned CHAN_HI       = 4;
  localparam int unsigned CHAN_LO       = 3;
  localparam logic [1:0]  CHAN_DEFAULT  = 2'h0;
  localparam logic [11:0] DAC_START     = 12'h800;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
    logic comp;
  } asfs_pins_t;

  localparam asfs_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0, comp: 1'b0};

  typedef enum logic [1:0] {
    PH_IDLE  = 2'h0,
    PH_TRACK = 2'h1,
    PH_CONV  = 2'h3
  } asfs_phase_t;
endpackage

//--- design/asfs_top.sv
// frame sequencer and successive-approximation control of a four-input serial converter
// How it works
// - track for first three clocks of slot
// - hold and convert clocks four to sixteen
// - sample taken on fourth falling clock edge
// - chip select low spans one framed transfer
// - result out, next channel in, each slot
// - conversions start sixteen clocks apart within a frame
// - step DAC word until comparator balances
// - result MSB first from clock five; float
// - first eight rising edges capture control byte
// - byte bits four and three pick channel
// - first conversion after reset uses input one
`timescale 1ns/10ps
`default_nettype none
module asfs_top (
  input  wire logic                     MCLK_I,
  input  wire logic                     RST_N_I,
  input  wire logic                     SCLK_I,
  input  wire logic                     CS_N_I,
  input  wire logic                     DIN_I,
  input  wire logic                     COMP_I,
  output logic                          TRACK_O,
  output logic [asfs_pkg::CHAN_W-1:0]   MUX_SEL_O,
  output logic [asfs_pkg::RES_W-1:0]    DAC_WORD_O,
  output logic                          DOUT_O,
  output logic                          DOUT_OE_N_O,
  output logic [asfs_pkg::RES_W-1:0]    RESULT_O,
  output logic                          RESULT_VALID_O
);
  import asfs_pkg::*;

  asfs_pins_t            pin_meta_reg;
  asfs_pins_t            pin_sync_reg;
  logic                  sclk_gated;
  logic                  sclk_prev_reg;
  logic                  sclk_fall;
  logic                  sclk_rise;
  asfs_phase_t           phase_reg;
  logic [IDX_W-1:0]      fall_idx_reg;
  logic [IDX_W-1:0]      fall_idx_next;
  logic [IDX_W-1:0]      rise_idx_reg;
  logic [CTL_W-2:0]      ctl_reg;
  logic [CTL_W-1:0]      ctl_byte;
  logic [CHAN_W-1:0]     chan_pend_reg;
  logic [RES_W-1:0]      dac_reg;
  logic [RES_W-1:0]      sar_next;
  logic [IDX_W-1:0]      bit_pos;
  logic                  bit_slot;

  // pins come from the host's domain
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_meta_reg <= PINS_IDLE;
      pin_sync_reg <= PINS_IDLE;
    end else begin
      pin_meta_reg <= '{sclk: SCLK_I, cs_n: CS_N_I, din: DIN_I, comp: COMP_I};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // serial clock is held high while deselected, so a select fall with the clock
  // low counts as the first falling edge
  assign sclk_gated = pin_sync_reg.sclk | pin_sync_reg.cs_n;
  assign sclk_fall  = sclk_prev_reg & ~sclk_gated;
  assign sclk_rise  = ~sclk_prev_reg & sclk_gated & ~pin_sync_reg.cs_n;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sclk_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_gated;
    end
  end

  // slot position: the first fall of a frame is index zero, the count wraps every slot
  assign fall_idx_next = (phase_reg == PH_IDLE) ? '0 : IDX_W'(fall_idx_reg + 1'b1);

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      phase_reg    <= PH_IDLE;
      fall_idx_reg <= '0;
      TRACK_O      <= 1'b0;
    end else if (pin_sync_reg.cs_n) begin
      phase_reg    <= PH_IDLE;
      fall_idx_reg <= '0;
      TRACK_O      <= 1'b0;
    end else if (sclk_fall) begin
      fall_idx_reg <= fall_idx_next;
      if (fall_idx_next == '0) begin
        phase_reg <= PH_TRACK;
        TRACK_O   <= 1'b1;
      end else if (fall_idx_next == HOLD_IDX) begin
        phase_reg <= PH_CONV;
        TRACK_O   <= 1'b0;
      end
    end
  end

  // control byte on the first eight rising edges of each slot
  assign ctl_byte = {ctl_reg, pin_sync_reg.din};

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rise_idx_reg  <= '0;
      ctl_reg       <= '0;
      chan_pend_reg <= CHAN_DEFAULT;
    end else if (pin_sync_reg.cs_n) begin
      rise_idx_reg <= '0;
    end else if (sclk_fall && fall_idx_next == '0) begin
      rise_idx_reg <= '0;
    end else if (sclk_rise && rise_idx_reg < CTL_BITS) begin
      ctl_reg      <= ctl_byte[CTL_W-2:0];
      rise_idx_reg <= IDX_W'(rise_idx_reg + 1'b1);
      if (rise_idx_reg == CTL_BITS - 1'b1) begin
        chan_pend_reg <= ctl_byte[CHAN_HI:CHAN_LO];
      end
    end
  end

  // the channel chosen in one slot is tracked in the next
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MUX_SEL_O <= CHAN_DEFAULT;
    end else if (!pin_sync_reg.cs_n && sclk_fall && fall_idx_next == '0) begin
      MUX_SEL_O <= chan_pend_reg;
    end
  end

  // one trial bit per falling edge; comparator high keeps the bit
  assign bit_slot = (phase_reg == PH_CONV) && (fall_idx_next >= FIRST_BIT_IDX);

  always_comb begin
    sar_next = dac_reg;
    bit_pos  = IDX_W'(LAST_IDX - fall_idx_next);
    if (bit_slot) begin
      sar_next[bit_pos] = pin_sync_reg.comp;
      if (bit_pos != '0) begin
        sar_next[IDX_W'(bit_pos - 1'b1)] = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dac_reg <= '0;
    end else if (!pin_sync_reg.cs_n && sclk_fall) begin
      if (phase_reg == PH_TRACK && fall_idx_next == HOLD_IDX) begin
        dac_reg <= DAC_START;
      end else if (bit_slot) begin
        dac_reg <= sar_next;
      end
    end
  end

  assign DAC_WORD_O = dac_reg;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RESULT_O       <= '0;
      RESULT_VALID_O <= 1'b0;
    end else begin
      RESULT_VALID_O <= 1'b0;
      if (!pin_sync_reg.cs_n && sclk_fall && bit_slot && fall_idx_next == LAST_IDX) begin
        RESULT_O       <= sar_next;
        RESULT_VALID_O <= 1'b1;
      end
    end
  end

  // serial out: prior slot's last bit kept through the slot's first fall, zeros after, then each decided bit as it settles
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DOUT_O      <= 1'b0;
      DOUT_OE_N_O <= 1'b1;
    end else begin
      DOUT_OE_N_O <= pin_sync_reg.cs_n;
      if (pin_sync_reg.cs_n) begin
        DOUT_O <= 1'b0;
      end else if (sclk_fall) begin
        if (bit_slot) begin
          DOUT_O <= pin_sync_reg.comp;
        end else if (fall_idx_next != '0) begin
          DOUT_O <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  a_track_start: assert property (
    !pin_sync_reg.cs_n && sclk_fall && fall_idx_next == '0 |=> TRACK_O && phase_reg == PH_TRACK)
    else $error("track not entered at slot start");
  a_hold_fourth: assert property (
    !pin_sync_reg.cs_n && sclk_fall && phase_reg == PH_TRACK && fall_idx_next == HOLD_IDX
    |=> !TRACK_O && phase_reg == PH_CONV && fall_idx_reg == HOLD_IDX)
    else $error("sample not taken at fourth fall");
  a_conv_holds: assert property (
    phase_reg == PH_CONV && !sclk_fall && !pin_sync_reg.cs_n |=> phase_reg == PH_CONV && !TRACK_O)
    else $error("conversion left without a clock fall");
  a_sar_start: assert property (
    !pin_sync_reg.cs_n && sclk_fall && phase_reg == PH_TRACK && fall_idx_next == HOLD_IDX
    |=> DAC_WORD_O == DAC_START)
    else $error("trial word not at mid scale");
  a_result_word: assert property (
    RESULT_VALID_O |-> RESULT_O == DAC_WORD_O && fall_idx_reg == LAST_IDX)
    else $error("result differs from balanced word");
  a_result_gap: assert property (
    RESULT_VALID_O |=> !RESULT_VALID_O [*8])
    else $error("results too close together");
  a_dout_float: assert property (
    pin_sync_reg.cs_n |=> DOUT_OE_N_O && !DOUT_O)
    else $error("serial out driven while deselected");
  a_dout_msb: assert property (
    !pin_sync_reg.cs_n && sclk_fall && phase_reg == PH_CONV && fall_idx_next == FIRST_BIT_IDX
    |=> DOUT_O == $past(pin_sync_reg.comp) && DAC_WORD_O[RES_W-1] == DOUT_O)
    else $error("first result bit wrong");
  a_chan_capture: assert property (
    !pin_sync_reg.cs_n && sclk_rise && rise_idx_reg == CTL_BITS - 1'b1
    |=> chan_pend_reg == $past(ctl_byte[CHAN_HI:CHAN_LO]))
    else $error("channel not taken from control byte");
  a_chan_apply: assert property (
    !pin_sync_reg.cs_n && sclk_fall && fall_idx_next == '0 |=> MUX_SEL_O == $past(chan_pend_reg))
    else $error("channel not applied at slot start");
  a_chan_default: assert property (
    $rose(RST_N_I) |-> MUX_SEL_O == CHAN_DEFAULT)
    else $error("first channel not input one");
  a_abandon: assert property (
    pin_sync_reg.cs_n |=> phase_reg == PH_IDLE && fall_idx_reg == '0 && !TRACK_O)
    else $error("slot not abandoned on deselect");
endmodule
`default_nettype wire

//--- testbench/asfs_host_model.sv
// host serial port and comparator model facing the frame sequencer
`timescale 1ns/10ps
`default_nettype none
module asfs_host_model (
  input  wire logic        mclk_i,
  input  wire logic [11:0] dac_word_i,
  input  wire logic [1:0]  mux_sel_i,
  input  wire logic        track_i,
  input  wire logic        dout_i,
  input  wire logic        dout_oe_n_i,
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic             din_o,
  output logic             comp_o
);
  logic [11:0] ana [4];
  logic [7:0]  q_ctl [$];
  logic [11:0] q_dout [$];
  logic [15:0] q_trk [$];
  logic [1:0]  q_mux [$];
  logic        flip = 1'b0;
  logic        line;
  // a floating data line shows a toggling pattern, never the last bit
  always @(posedge mclk_i) flip <= ~flip;
  assign line = dout_oe_n_i ? flip : dout_i;
  assign comp_o = ana[mux_sel_i] >= dac_word_i;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // cut > 0 raises chip select after that many rises of the last slot
  task automatic frame(input int slots, input int cut);
    logic [7:0]  c;
    logic [11:0] d;
    logic [15:0] t;
    int          k;
    @(posedge mclk_i);
    #1 cs_n_o = 1'b0;
    for (int s = 0; s < slots; s++) begin
      c = q_ctl.pop_front();
      for (k = 1; k <= 16; k++) begin
        din_o = (k <= 8) ? c[8-k] : flip;
        repeat (4) @(posedge mclk_i);
        #1 t[k-1] = track_i;
        if (k == 1) q_mux.push_back(mux_sel_i);
        if (k >= 5) d[16-k] = line;
        sclk_o = 1'b1;
        repeat (4) @(posedge mclk_i);
        #1 if (s == slots - 1 && (k == 16 || k == cut)) break;
        sclk_o = 1'b0;
      end
      if (k >= 16) begin
        q_dout.push_back(d);
        q_trk.push_back(t);
      end
    end
    cs_n_o = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1 sclk_o = 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

//--- testbench/asfs_top_tb_top.sv
// self-checking bench of the frame sequencer against the host model
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin logic [31:0] ev, sv; ev = 32'(e); sv = 32'(s); checks++; \
  if (sv !== ev) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, ev, sv); end end
module asfs_top_tb_top;
  import asfs_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sclk, cs_n, din, comp, track, dout, oe_n, vld;
  logic [1:0]  mux;
  logic [11:0] dac, res, e;
  logic [1:0]  ch = CHAN_DEFAULT;
  int          n_mismatch = 0;
  int          checks = 0;
  int          seed = 9;
  int          n_vld = 0;
  int          exp_vld = 0;
  int          nslot = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (vld === 1'b1) n_vld++;
  asfs_top uut (.MCLK_I(mclk), .RST_N_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din),
    .COMP_I(comp), .TRACK_O(track), .MUX_SEL_O(mux), .DAC_WORD_O(dac), .DOUT_O(dout),
    .DOUT_OE_N_O(oe_n), .RESULT_O(res), .RESULT_VALID_O(vld));
  asfs_host_model host (.mclk_i(mclk), .dac_word_i(dac), .mux_sel_i(mux), .track_i(track),
    .dout_i(dout), .dout_oe_n_i(oe_n), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .comp_o(comp));
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // successive approximation of an ideal converter: keep a trial bit while the input reaches it
  function automatic logic [RES_W-1:0] sar_code(input logic [RES_W-1:0] v);
    logic [RES_W-1:0] w;
    w = '0;
    for (int b = RES_W - 1; b >= 0; b--) begin
      w[b] = 1'b1;
      if (v < w) w[b] = 1'b0;
    end
    return w;
  endfunction
  task automatic run(input int slots, input int cut);
    logic [7:0] c;
    logic [1:0] m [$];
    int         k;
    for (int s = 0; s < slots; s++) begin
      c = 8'($random(seed));
      if (nslot < 4) c[4:3] = nslot[1:0];
      nslot++;
      host.q_ctl.push_back(c);
      m.push_back(ch);
      if (s < slots - 1 || cut == 0 || cut >= 8) ch = c[4:3];
    end
    host.frame(slots, cut);
    k = (cut == 0) ? slots : slots - 1;
    exp_vld += k;
    repeat (k) begin
      e = sar_code(host.ana[m[0]]);
      `CHK("mux", m.pop_front(), host.q_mux.pop_front())
      `CHK("track", 16'h0007, host.q_trk.pop_front())
      `CHK("dout", e, host.q_dout.pop_front())
    end
    if (cut != 0) `CHK("mux_cut", m.pop_front(), host.q_mux.pop_front())
    if (k > 0) `CHK("result", e, res)
    `CHK("valid_cnt", exp_vld, n_vld)
    `CHK("oe_n_idle", 1'b1, oe_n)
    `CHK("dout_idle", 1'b0, dout)
  endtask
  initial begin
    host.ana = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("result_rst", 12'h000, res)
    run(4, 0);
    run(1, 5);
    run(2, 11);
    run(1, 0);
    repeat (6) begin
      for (int i = 0; i < 4; i++) host.ana[i] = 12'($random(seed));
      run(1 + ($unsigned($random(seed)) % 3), 0);
    end
    results();
  end
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
